// [rtl/csocp_consts.svh]
// Purpose: Offsets, field positions, reset values and timing for the sense trim bank
// Assumes: Core clock of 10 MHz
// Notes:   Included by the top module and the blanking timer
`ifndef CSOCP_CONSTS_SVH
`define CSOCP_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CSOCP_ADDR_PRI_READING 8'h13
`define CSOCP_ADDR_PRI_OCP 8'h22
`define CSOCP_ADDR_SEC_GAIN 8'h23

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CSOCP_BLANK_MSB 7
`define CSOCP_BLANK_LSB 5
`define CSOCP_THRESH_MSB 4
`define CSOCP_THRESH_LSB 0
`define CSOCP_NOM_MSB 7
`define CSOCP_NOM_LSB 6
`define CSOCP_POL_BIT 5
`define CSOCP_TRIM_MSB 4
`define CSOCP_TRIM_LSB 0
`define CSOCP_PRI_OCP_RST 8'h00
`define CSOCP_SEC_GAIN_RST 8'h00
`define CSOCP_RDATA_ZERO 8'h00

// ---------------------------------------------------------------
// Full scale and step size per nominal code (uV and nV)
// ---------------------------------------------------------------
`define CSOCP_FS_UV_00 18'h0_927C
`define CSOCP_FS_UV_01 18'h1_24F8
`define CSOCP_FS_UV_10 18'h2_49F0
`define CSOCP_FS_UV_BAD 18'h0_0000
`define CSOCP_STEP_NV_00 16'h3_B9C
`define CSOCP_STEP_NV_01 16'h7_738
`define CSOCP_STEP_NV_10 16'hE_E70
`define CSOCP_STEP_NV_BAD 16'h0_000

// ---------------------------------------------------------------
// Blanking times in ns and their cycle counts, rounded up
// ---------------------------------------------------------------
`define CSOCP_CLK_MHZ 10
`define CSOCP_NS_TO_CYC(ns) (((ns) * `CSOCP_CLK_MHZ + 999) / 1000)
`define CSOCP_BLANK0_NS 0
`define CSOCP_BLANK1_NS 40
`define CSOCP_BLANK2_NS 80
`define CSOCP_BLANK3_NS 120
`define CSOCP_BLANK4_NS 200
`define CSOCP_BLANK5_NS 400
`define CSOCP_BLANK6_NS 600
`define CSOCP_BLANK7_NS 800
`define CSOCP_CNT_W 4

`endif

// [rtl/csocp_pkg.sv]
// Purpose: Types shared by the sense trim bank
// Assumes: Nothing beyond the constants header
// Notes:   States use explicit binary codes
package csocp_pkg;
   typedef enum logic [1:0] {
      CSOCP_ST_IDLE = 2'b00,
      CSOCP_ST_BLANK = 2'b01,
      CSOCP_ST_ARMED = 2'b10
   } csocp_blank_st_t;
endpackage

// [rtl/csocp_blank_timer.sv]
// Purpose: Blanking delay before quick overcurrent detection is armed
// Assumes: i_cycle_start is a one-cycle pulse on the core clock
// Notes:   A new cycle start restarts blanking from any state
`timescale 1ns/1ps
`include "csocp_consts.svh"
module csocp_blank_timer import csocp_pkg::*; (
   input wire logic i_clk,          // Core clock
   input wire logic i_rst_n,        // Sync reset, active low
   input wire logic i_cycle_start,  // Switching cycle start pulse
   input wire logic [2:0] i_sel,    // Blanking code
   output logic o_enable            // Detection armed
);
   csocp_blank_st_t state_ff;
   logic [`CSOCP_CNT_W-1:0] cnt_ff;
   logic [`CSOCP_CNT_W-1:0] nxt_cnt;

   // ---------------------------------------------------------------
   // Code to cycle count
   // ---------------------------------------------------------------
   function automatic logic [`CSOCP_CNT_W-1:0] blank_cycles(input logic [2:0] code);
      unique case (code)
         3'd0: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK0_NS));
         3'd1: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK1_NS));
         3'd2: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK2_NS));
         3'd3: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK3_NS));
         3'd4: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK4_NS));
         3'd5: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK5_NS));
         3'd6: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK6_NS));
         3'd7: blank_cycles = `CSOCP_CNT_W'(`CSOCP_NS_TO_CYC(`CSOCP_BLANK7_NS));
      endcase
   endfunction

   assign nxt_cnt = blank_cycles(i_sel);

   // Blanking sequence; zero code arms on the cycle after the start
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_ff <= CSOCP_ST_IDLE;
         cnt_ff <= '0;
         o_enable <= 1'b0;
      end else if (i_cycle_start) begin
         cnt_ff <= nxt_cnt;
         state_ff <= (nxt_cnt == '0) ? CSOCP_ST_ARMED : CSOCP_ST_BLANK;
         o_enable <= (nxt_cnt == '0);
      end else begin
         unique case (state_ff)
            CSOCP_ST_IDLE: begin
               o_enable <= 1'b0;
            end
            CSOCP_ST_BLANK: begin
               // Count out the blanking window, then arm
               if (cnt_ff == `CSOCP_CNT_W'(1)) begin
                  state_ff <= CSOCP_ST_ARMED;
                  o_enable <= 1'b1;
               end
               cnt_ff <= cnt_ff - `CSOCP_CNT_W'(1);
            end
            CSOCP_ST_ARMED: begin
               o_enable <= 1'b1;
            end
            default: begin
               state_ff <= CSOCP_ST_IDLE;
               o_enable <= 1'b0;
            end
         endcase
      end
   end
endmodule

// [rtl/csocp_trim_bank.sv]
// Purpose: Sense channel trim registers and primary precise overcurrent compare
// Assumes: Serial management logic presents decoded register reads and writes
// Notes:   Converter reading arrives on the core clock, so it is not synchronised
`timescale 1ns/1ps
`include "csocp_consts.svh"
module csocp_trim_bank import csocp_pkg::*; #(
   parameter int P_READ_W = 8,   // Primary converter reading width
   parameter int P_THRESH_W = 5  // Threshold field width
) (
   input wire logic I_CORE_CLK,                    // Core clock, 10 MHz
   input wire logic I_RST_N,                       // Sync reset, active low
   input wire logic [7:0] I_REG_ADDR,              // Register offset
   input wire logic I_REG_WR,                      // Write strobe
   input wire logic [7:0] I_REG_WDATA,             // Write data
   input wire logic I_REG_RD,                      // Read strobe
   input wire logic [P_READ_W-1:0] I_PRI_READING,  // Primary converter reading
   input wire logic I_SW_CYCLE_START,              // Switching cycle start pulse
   output logic [7:0] O_REG_RDATA,                 // Read data
   output logic O_PRI_PRECISE_OCP,                 // Primary overcurrent flag
   output logic O_PRI_QUICK_OCP_EN,                // Quick detection armed
   output logic [17:0] O_SEC_FULL_SCALE_UV,        // Full-scale drop, uV
   output logic [15:0] O_SEC_STEP_NV,              // Converter step, nV
   output logic signed [5:0] O_SEC_GAIN_CORR       // Signed gain correction
);
   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (P_THRESH_W != 5 || P_READ_W < P_THRESH_W || P_READ_W > 8) begin : g_bad_width
      $error("csocp_trim_bank: unsupported widths");
   end

   logic [7:0] pri_ocp_ff;
   logic [7:0] sec_gain_ff;
   logic [P_READ_W-1:0] nxt_thresh;
   logic [1:0] nom_code;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Primary setting: blanking code and precise threshold
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         pri_ocp_ff <= `CSOCP_PRI_OCP_RST;
      end else if (I_REG_WR && I_REG_ADDR == `CSOCP_ADDR_PRI_OCP) begin
         pri_ocp_ff <= I_REG_WDATA;
      end
   end

   // Secondary gain trim register
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         sec_gain_ff <= `CSOCP_SEC_GAIN_RST;
      end else if (I_REG_WR && I_REG_ADDR == `CSOCP_ADDR_SEC_GAIN) begin
         sec_gain_ff <= I_REG_WDATA;
      end
   end

   // Read path; unmapped offsets read zero
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_REG_RDATA <= `CSOCP_RDATA_ZERO;
      end else if (I_REG_RD) begin
         unique case (I_REG_ADDR)
            `CSOCP_ADDR_PRI_READING: O_REG_RDATA <= 8'(I_PRI_READING);
            `CSOCP_ADDR_PRI_OCP: O_REG_RDATA <= pri_ocp_ff;
            `CSOCP_ADDR_SEC_GAIN: O_REG_RDATA <= sec_gain_ff;
            default: O_REG_RDATA <= `CSOCP_RDATA_ZERO;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Primary precise overcurrent compare
   // ---------------------------------------------------------------
   // Threshold is zero-extended to the reading's width; no trim gating in
   // hardware, so a threshold written before trim compares raw readings
   assign nxt_thresh = P_READ_W'(pri_ocp_ff[`CSOCP_THRESH_MSB:`CSOCP_THRESH_LSB]);

   // Level flag, follows the reading one cycle late
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_PRI_PRECISE_OCP <= 1'b0;
      end else begin
         O_PRI_PRECISE_OCP <= (I_PRI_READING > nxt_thresh);
      end
   end

   // ---------------------------------------------------------------
   // Quick overcurrent blanking
   // ---------------------------------------------------------------
   csocp_blank_timer u_blank (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_cycle_start(I_SW_CYCLE_START),
      .i_sel(pri_ocp_ff[`CSOCP_BLANK_MSB:`CSOCP_BLANK_LSB]),
      .o_enable(O_PRI_QUICK_OCP_EN)
   );

   // ---------------------------------------------------------------
   // Secondary range decode and gain correction
   // ---------------------------------------------------------------
   assign nom_code = sec_gain_ff[`CSOCP_NOM_MSB:`CSOCP_NOM_LSB];

   // Reserved code 11 reports zero so a bad setting is visible downstream
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_SEC_FULL_SCALE_UV <= `CSOCP_FS_UV_00;
         O_SEC_STEP_NV <= `CSOCP_STEP_NV_00;
      end else begin
         unique case (nom_code)
            2'b00: begin
               O_SEC_FULL_SCALE_UV <= `CSOCP_FS_UV_00;
               O_SEC_STEP_NV <= `CSOCP_STEP_NV_00;
            end
            2'b01: begin
               O_SEC_FULL_SCALE_UV <= `CSOCP_FS_UV_01;
               O_SEC_STEP_NV <= `CSOCP_STEP_NV_01;
            end
            2'b10: begin
               O_SEC_FULL_SCALE_UV <= `CSOCP_FS_UV_10;
               O_SEC_STEP_NV <= `CSOCP_STEP_NV_10;
            end
            2'b11: begin
               O_SEC_FULL_SCALE_UV <= `CSOCP_FS_UV_BAD;
               O_SEC_STEP_NV <= `CSOCP_STEP_NV_BAD;
            end
         endcase
      end
   end

   // Sign-magnitude trim to two's complement for the gain stage
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_SEC_GAIN_CORR <= '0;
      end else if (sec_gain_ff[`CSOCP_POL_BIT]) begin
         O_SEC_GAIN_CORR <= -$signed({1'b0, sec_gain_ff[`CSOCP_TRIM_MSB:`CSOCP_TRIM_LSB]});
      end else begin
         O_SEC_GAIN_CORR <= $signed({1'b0, sec_gain_ff[`CSOCP_TRIM_MSB:`CSOCP_TRIM_LSB]});
      end
   end
endmodule

// [sim/csocp_trim_bank_checker.sv]
// Purpose: Port assertions for the sense trim bank
// Assumes: One core clock, synchronous active-low reset
// Notes:   Shadows both settings registers from the write strobes
`timescale 1ns/1ps
module csocp_trim_bank_checker #(
   parameter int P_READ_W = 8  // Reading width
) (
   input wire logic I_CORE_CLK,  // Clock
   input wire logic I_RST_N,  // Reset
   input wire logic [7:0] I_REG_ADDR,  // Offset
   input wire logic I_REG_WR,  // Write
   input wire logic [7:0] I_REG_WDATA,  // Write data
   input wire logic I_REG_RD,  // Read
   input wire logic [P_READ_W-1:0] I_PRI_READING,  // Reading
   input wire logic I_SW_CYCLE_START,  // Cycle start
   input wire logic [7:0] O_REG_RDATA,  // Read data
   input wire logic O_PRI_PRECISE_OCP,  // Flag
   input wire logic O_PRI_QUICK_OCP_EN,  // Armed
   input wire logic [17:0] O_SEC_FULL_SCALE_UV,  // Full scale
   input wire logic [15:0] O_SEC_STEP_NV,  // Step
   input wire logic signed [5:0] O_SEC_GAIN_CORR  // Gain
);
   localparam logic [3:0] BLANK_CYC [8] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h6, 4'h8};
   localparam logic [17:0] FS_UV [4] = '{18'h0_927C, 18'h1_24F8, 18'h2_49F0, 18'h0_0000};
   localparam logic [15:0] STEP_NV [4] = '{16'h3B9C, 16'h7738, 16'hEE70, 16'h0000};
   logic [7:0] pri_ff;
   logic [7:0] sec_ff;
   logic [3:0] cnt_ff;
   logic [2:0] code_ff;
   logic [7:0] rd_exp;
   logic [5:0] gain_exp;
   // ---------------------------------------------------------------
   // Shadow state
   // ---------------------------------------------------------------
   // Only the two settings offsets take writes
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         pri_ff <= 8'h00;
         sec_ff <= 8'h00;
      end else if (I_REG_WR) begin
         if (I_REG_ADDR == 8'h22) pri_ff <= I_REG_WDATA;
         if (I_REG_ADDR == 8'h23) sec_ff <= I_REG_WDATA;
      end
   end
   // Cycles since start, saturating so long runs stay cheap
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         cnt_ff <= 4'h0;
         code_ff <= 3'h0;
      end else if (I_SW_CYCLE_START) begin
         cnt_ff <= 4'h1;
         code_ff <= pri_ff[7:5];
      end else if (cnt_ff != 4'h0 && cnt_ff != 4'hF) begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   // Expected read data and gain pattern
   assign rd_exp = (I_REG_ADDR == 8'h13) ? 8'(I_PRI_READING) : (I_REG_ADDR == 8'h22) ?
      pri_ff : (I_REG_ADDR == 8'h23) ? sec_ff : 8'h00;
   assign gain_exp = sec_ff[5] ? 6'h00 - {1'b0, sec_ff[4:0]} : {1'b0, sec_ff[4:0]};
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   a_flag_compare:
      assert property (O_PRI_PRECISE_OCP == ($past(I_PRI_READING) > $past(pri_ff[4:0])))
      else $error("flag compare wrong");
   a_zero_thresh_sets:
      assert property ((pri_ff[4:0] == 5'h00 && I_PRI_READING != '0) |=> O_PRI_PRECISE_OCP)
      else $error("zero threshold flag missing");
   a_full_scale_map:
      assert property (O_SEC_FULL_SCALE_UV == FS_UV[$past(sec_ff[7:6])])
      else $error("full scale wrong");
   a_step_size_map:
      assert property (O_SEC_STEP_NV == STEP_NV[$past(sec_ff[7:6])])
      else $error("step size wrong");
   a_gain_corr_sign:
      assert property ($unsigned(O_SEC_GAIN_CORR) == $past(gain_exp))
      else $error("gain correction wrong");
   a_blank_delay:
      assert property (O_PRI_QUICK_OCP_EN == (cnt_ff > BLANK_CYC[code_ff]))
      else $error("blanking delay wrong");
   a_read_data:
      assert property (I_REG_RD |=> O_REG_RDATA == $past(rd_exp))
      else $error("read data wrong");
   a_read_hold:
      assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
      else $error("read data moved");
endmodule
bind csocp_trim_bank csocp_trim_bank_checker #(.P_READ_W(P_READ_W)) chk_inst (.I_CORE_CLK,
   .I_RST_N, .I_REG_ADDR, .I_REG_WR, .I_REG_WDATA, .I_REG_RD, .I_PRI_READING,
   .I_SW_CYCLE_START, .O_REG_RDATA, .O_PRI_PRECISE_OCP, .O_PRI_QUICK_OCP_EN,
   .O_SEC_FULL_SCALE_UV, .O_SEC_STEP_NV, .O_SEC_GAIN_CORR);

// [sim/csocp_trim_bank_test.sv]
// Purpose: Self-checking bench for the sense trim bank
// Assumes: Checker is bound from its own file
// Notes:   Expectations come from bench tables, never from outputs
`timescale 1ns/1ps
module csocp_trim_bank_test;
   localparam logic [3:0] BLANK_CYC [8] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h6, 4'h8};
   localparam logic [17:0] FS_UV [4] = '{18'h0_927C, 18'h1_24F8, 18'h2_49F0, 18'h0_0000};
   localparam logic [15:0] STEP_NV [4] = '{16'h3B9C, 16'h7738, 16'hEE70, 16'h0000};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic rd = 1'b0;
   logic [7:0] rdg = 8'h00;
   logic start = 1'b0;
   logic [7:0] rdata;
   logic ocp;
   logic qen;
   logic [17:0] fs;
   logic [15:0] step;
   logic signed [5:0] gain;
   logic [7:0] v;
   int bad_count = 0;
   int n_checks = 0;
   int k;
   always #50 clk = ~clk;
   csocp_trim_bank csocp_trim_bank_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr),
      .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd), .I_PRI_READING(rdg),
      .I_SW_CYCLE_START(start), .O_REG_RDATA(rdata), .O_PRI_PRECISE_OCP(ocp),
      .O_PRI_QUICK_OCP_EN(qen), .O_SEC_FULL_SCALE_UV(fs), .O_SEC_STEP_NV(step),
      .O_SEC_GAIN_CORR(gain));
   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Data is registered, so look one edge after the strobe lands
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      #1 chk("rdata", {10'h000, exp}, {10'h000, rdata});
   endtask
   // Pulse a cycle start and count edges until detection is armed;
   // look just after each edge so the enable has settled
   task automatic blank_run(output int n);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      n = 0;
      while (n < 12 && qen !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic stop_test;
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(32'h64f8_26c0));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rdg <= 8'h5A;
      repeat (2) @(posedge clk);
      #1 chk("ocp", 18'h0_0001, {17'h0_0000, ocp});
      rd_chk(8'h22, 8'h00);
      wr_reg(8'h13, 8'hFF);
      rd_chk(8'h13, 8'h5A);
      rd_chk(8'h41, 8'h00);
      // Every nominal code, reserved one too; trim 31 negative once
      for (int n = 0; n < 4; n++) begin
         v = {n[1:0], 6'($urandom) | ((n == 1) ? 6'h3F : 6'h00)};
         wr_reg(8'h23, v);
         repeat (2) @(posedge clk);
         #1 chk("fs", FS_UV[v[7:6]], fs);
         chk("step", {2'h0, STEP_NV[v[7:6]]}, {2'h0, step});
         chk("gain", {12'h000, v[5] ? 6'h00 - {1'b0, v[4:0]} : {1'b0, v[4:0]}},
            {12'h000, gain});
         rd_chk(8'h23, v);
      end
      // Readings just below, at and above each threshold, below wrapping to FF for threshold zero; trim is set first
      for (int i = 0; i < 10; i++) begin
         v = {3'h0, (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom)};
         wr_reg(8'h22, v);
         for (int d = -1; d < 2; d++) begin
            @(posedge clk);
            rdg <= 8'(int'(v) + d);
            repeat (2) @(posedge clk);
            #1 chk("ocp", {17'h0_0000, rdg > v}, {17'h0_0000, ocp});
         end
      end
      for (int c = 0; c < 8; c++) begin
         wr_reg(8'h22, {c[2:0], 5'h1F});
         blank_run(k);
         chk("blank", {14'h0000, BLANK_CYC[c]}, 18'(k));
      end
      // Second start in mid blanking restarts the count
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      blank_run(k);
      chk("restart", {14'h0000, BLANK_CYC[7]}, 18'(k));
      // Random traffic; the bound checker judges every cycle
      repeat (300) begin
         @(posedge clk);
         rdg <= 8'($urandom);
         start <= ($urandom_range(7) == 0);
         rd <= 1'($urandom_range(1));
         wr <= ($urandom_range(15) == 0);
         wdata <= 8'($urandom);
         addr <= 8'h13 + 8'($urandom_range(16));
      end
      @(posedge clk);
      start <= 1'b0;
      rd <= 1'b0;
      wr <= 1'b0;
      repeat (3) @(posedge clk);
      stop_test();
   end
   // Tests need under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule
